/* File: bench/debug_host_model.sv */
/*
 * Model of the external debugger and the unconditional-event pin:
 * drives the request and restart lines, held for a chosen length.
 * Assumes the bench calls pulse from its own clocked sequence.
 */
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic clk_in,
  output logic      ext_unc_out,
  output logic      jtag_unc_out,
  output logic      jtag_resume_out
);
  // ****************************************
  // Line drivers
  // ****************************************
  initial begin
    ext_unc_out = 1'b0;
    jtag_unc_out = 1'b0;
    jtag_resume_out = 1'b0;
  end

  // Raise one line after an edge, hold it len cycles, release it
  task automatic pulse(input int sel, input int len);
    @(posedge clk_in);
    case (sel)
      0: ext_unc_out <= 1'b1;
      1: jtag_unc_out <= 1'b1;
      default: jtag_resume_out <= 1'b1;
    endcase
    repeat (len) @(posedge clk_in);
    ext_unc_out <= 1'b0;
    jtag_unc_out <= 1'b0;
    jtag_resume_out <= 1'b0;
  endtask
endmodule

/* File: bench/test_debug_event_detector.sv */
/*
 * Self-checking bench for the debug-event detector: register access,
 * exception, trap, unconditional and address-compare events.
 * Assumes the detector, its package and the debugger model.
 */
`timescale 1ns/1ps
module test_debug_event_detector import debug_event_pkg::*; ();
  localparam logic [31:0] VEC = 32'h0000_0500;
  logic        clk_in;
  logic        rst_n_in;
  core_step_t  step_in;
  logic        de;
  logic        ack;
  reg_req_t    req_in;
  logic [31:0] rdata_out;
  logic        debug_event_out;
  logic        debug_int_out;
  logic        stop_out;
  logic        trap_suppress_out;
  logic        ext_unc;
  logic        jtag_unc;
  logic        jtag_res;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          md[3] = '{CTL_INT_MODE, CTL_EXT_MODE, CTL_WAIT_MODE};
  logic [31:0] ra[6] = '{32'hff, 32'h100, 32'h8000_0000, 32'h8fff_ffff,
                         32'h9000_0000, 32'hffff_ffff};

  debug_event_detector debug_event_detector_inst (
    .clk_in                (clk_in),
    .rst_n_in              (rst_n_in),
    .step_in               (step_in),
    .debug_int_enable_in   (de),
    .debug_int_ack_in      (ack),
    .ext_unconditional_in  (ext_unc),
    .jtag_unconditional_in (jtag_unc),
    .jtag_resume_in        (jtag_res),
    .req_in                (req_in),
    .rdata_out             (rdata_out),
    .debug_event_out       (debug_event_out),
    .debug_int_out         (debug_int_out),
    .stop_out              (stop_out),
    .trap_suppress_out     (trap_suppress_out)
  );

  debug_host_model debug_host_model_inst (
    .clk_in          (clk_in),
    .ext_unc_out     (ext_unc),
    .jtag_unc_out    (jtag_unc),
    .jtag_resume_out (jtag_res)
  );

  // ****************************************
  // Clock, timeout and helpers
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req_in <= {1'b1, 1'b0, a, d};
    @(posedge clk_in);
    req_in <= '0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    req_in <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clk_in);
    req_in <= '0;
    #1;
    chk(rdata_out, exp);
  endtask

  // One core step: valid, trap_hit, exc_taken, exc_critical
  task automatic go(input logic [3:0] f, input logic [31:0] a);
    @(posedge clk_in);
    step_in <= {f, a, a + 32'h4, VEC};
    @(posedge clk_in);
    step_in <= '0;
    #1;
  endtask

  task automatic ackp();
    @(posedge clk_in);
    ack <= 1'b1;
    @(posedge clk_in);
    ack <= 1'b0;
    #1;
  endtask

  // Bounded wait for event (k=0) or halt (k=1) to reach v
  task automatic wt(input int k, input logic v);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16 && !hit; i++) begin
      @(posedge clk_in);
      #1;
      hit = (((k == 0) ? debug_event_out : stop_out) === v);
    end
    chk(32'(hit), 32'h1);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    step_in = '0;
    req_in = '0;
    de = 1'b0;
    ack = 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(OFS_CONTROL, CONTROL_RESET);
    rd(OFS_STATUS, STATUS_RESET);
    rd(OFS_RETURN, RETURN_RESET);
    rd(OFS_CMP_4, CMP_RESET);
    wr(OFS_RETURN, 32'h1234_5678);
    rd(OFS_RETURN, RETURN_RESET);
    wr(5'h0c, 32'hffff_ffff);
    rd(5'h0c, 32'h0);
    wr(OFS_CONTROL, 32'hffff_ffff);
    rd(OFS_CONTROL, CONTROL_MASK);
    de <= 1'b1;
    wr(OFS_CONTROL, b(CTL_EXC_EN));
    go(4'b0010, 32'h40);
    chk(32'(debug_event_out), 32'h1);
    rd(OFS_STATUS, b(ST_EXC));
    rd(OFS_RETURN, VEC);
    wr(OFS_STATUS, 32'hff);
    go(4'b0011, 32'h40);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_CONTROL, b(CTL_EXC_EN) | b(CTL_EXT_MODE));
    go(4'b0011, 32'h40);
    chk(32'(stop_out), 32'h1);
    rd(OFS_STATUS, b(ST_EXC));
    debug_host_model_inst.pulse(2, 3);
    wt(1, 1'b0);
    wr(OFS_STATUS, 32'hff);
    wr(OFS_CONTROL, b(CTL_TRAP_EN));
    go(4'b1000, 32'h80);
    chk(32'(debug_event_out), 32'h0);
    go(4'b0100, 32'h80);
    chk(32'(debug_event_out), 32'h0);
    go(4'b1100, 32'h80);
    chk(32'(trap_suppress_out), 32'h0);
    rd(OFS_STATUS, b(ST_TRAP));
    rd(OFS_RETURN, 32'h80);
    for (int m = 0; m < 3; m++) begin
      wr(OFS_STATUS, 32'hff);
      wr(OFS_CONTROL, b(CTL_TRAP_EN) | b(md[m]));
      go(4'b1100, 32'h84 + 32'(m * 4));
      chk(32'(trap_suppress_out), 32'h1);
      debug_host_model_inst.pulse(2, 3);
      wt(1, 1'b0);
    end
    ackp();
    wr(OFS_STATUS, 32'hff);
    de <= 1'b0;
    wr(OFS_CONTROL, b(CTL_TRAP_EN) | b(CTL_INT_MODE));
    go(4'b1100, 32'h90);
    chk(32'(trap_suppress_out), 32'h0);
    chk(32'(debug_int_out), 32'h0);
    rd(OFS_STATUS, b(ST_TRAP) | b(ST_IMP));
    rd(OFS_RETURN, 32'h8c);
    @(posedge clk_in);
    de <= 1'b1;
    @(posedge clk_in);
    #1;
    chk(32'(debug_int_out), 32'h1);
    ackp();
    chk(32'(debug_int_out), 32'h0);
    wr(OFS_STATUS, 32'hff);
    wr(OFS_CONTROL, 32'h0);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_in);
      step_in <= {4'b1000, 32'h200, 32'h204, VEC};
      fork
        debug_host_model_inst.pulse(s, 3 + 6 * s);
        wt(0, 1'b1);
      join
      rd(OFS_STATUS, b(ST_UNC));
      rd(OFS_RETURN, 32'h204);
      wr(OFS_STATUS, 32'hff);
    end
    @(posedge clk_in);
    step_in <= '0;
    for (int n = 0; n < 4; n++) begin
      wr(OFS_CMP_1 + 5'(4 * n), 32'h1000 + 32'(16 * n));
    end
    wr(OFS_CONTROL, 32'hf << CTL_IA_EN);
    for (int n = 0; n < 4; n++) begin
      go(4'b1000, 32'h1000 + 32'(16 * n));
      go(4'b1000, 32'h2000);
      rd(OFS_STATUS, b(ST_IA + n));
      rd(OFS_RETURN, 32'h1000 + 32'(16 * n));
      wr(OFS_STATUS, b(ST_IA + n));
    end
    wr(OFS_CMP_1, 32'h100);
    wr(OFS_CMP_2, 32'h9000_0000);
    for (int x = 0; x < 2; x++) begin
      wr(OFS_CONTROL, b(CTL_IA_EN) | b(CTL_RANGE_A) | (x ? b(CTL_EXCL_A)
         : b(CTL_IA_EN + 1)));
      for (int i = 0; i < 6; i++) begin
        go(4'b1000, ra[i]);
        rd(OFS_STATUS, ((6'b001110 >> i) & 1) != x ? (x ? b(ST_IA) :
           b(ST_IA) | b(ST_IA + 1)) : 32'h0);
        wr(OFS_STATUS, 32'hff);
      end
    end
    rd(OFS_CONTROL, b(CTL_IA_EN) | b(CTL_RANGE_A) | b(CTL_EXCL_A));
    wr(OFS_CONTROL, b(CTL_IA_EN) | b(CTL_RANGE_A) | b(CTL_EXCL_A)
       | b(CTL_TOGGLE_A));
    go(4'b1000, 32'hff);
    rd(OFS_CONTROL, b(CTL_IA_EN) | b(CTL_RANGE_A) | b(CTL_TOGGLE_A));
    go(4'b1000, 32'hff);
    chk(32'(debug_event_out), 32'h0);
    go(4'b1000, 32'h100);
    rd(OFS_CONTROL, b(CTL_IA_EN) | b(CTL_RANGE_A) | b(CTL_EXCL_A)
       | b(CTL_TOGGLE_A));
    wr(OFS_STATUS, 32'hff);
    @(posedge clk_in);
    de <= 1'b0;
    wr(OFS_CONTROL, b(CTL_IA_EN) | b(CTL_RANGE_A) | b(CTL_EXCL_A)
       | b(CTL_TOGGLE_A) | b(CTL_INT_MODE));
    go(4'b1000, 32'hff);
    rd(OFS_STATUS, 32'h0);
    report_and_stop();
  end
endmodule

/* File: common/debug_event_pkg.sv */
/*
 * Shared constants and types for the debug-event detector: register
 * offsets, control and status bit positions, reset values, carriers.
 * Assumes a 32-bit core address space and one processor clock.
 */
package debug_event_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFS_CONTROL  = 5'h00;
  localparam logic [4:0]  OFS_STATUS   = 5'h04;
  localparam logic [4:0]  OFS_RETURN   = 5'h08;
  localparam logic [4:0]  OFS_CMP_1    = 5'h10;
  localparam logic [4:0]  OFS_CMP_2    = 5'h14;
  localparam logic [4:0]  OFS_CMP_3    = 5'h18;
  localparam logic [4:0]  OFS_CMP_4    = 5'h1c;

  // ****************************************
  // Control bits of debug_control_0
  // ****************************************
  localparam int CTL_EXT_MODE  = 0;
  localparam int CTL_INT_MODE  = 1;
  localparam int CTL_WAIT_MODE = 2;
  localparam int CTL_EXC_EN    = 3;
  localparam int CTL_TRAP_EN   = 4;
  localparam int CTL_IA_EN     = 5;
  localparam int CTL_RANGE_A   = 9;
  localparam int CTL_RANGE_B   = 10;
  localparam int CTL_EXCL_A    = 11;
  localparam int CTL_EXCL_B    = 12;
  localparam int CTL_TOGGLE_A  = 13;
  localparam int CTL_TOGGLE_B  = 14;
  localparam logic [31:0] CONTROL_MASK  = 32'h0000_7fff;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // ****************************************
  // Status bits of debug_event_status
  // ****************************************
  localparam int ST_EXC   = 0;
  localparam int ST_TRAP  = 1;
  localparam int ST_UNC   = 2;
  localparam int ST_IMP   = 3;
  localparam int ST_IA    = 4;
  localparam logic [31:0] STATUS_MASK  = 32'h0000_00ff;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] RETURN_RESET = 32'h0000_0000;
  localparam logic [31:0] CMP_RESET    = 32'h0000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        trap_hit;
    logic        exc_taken;
    logic        exc_critical;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic [31:0] exc_vector;
  } core_step_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

/* File: src/debug_event_detector.sv */
/*
 * Debug-event detector: exception-taken, trap, unconditional and
 * instruction address-compare events, status, return address, halt.
 * Assumes the core presents one resolved step per cycle on clk_in and
 * that register strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
module debug_event_detector
  import debug_event_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire core_step_t  step_in,
  input  wire logic        debug_int_enable_in,
  input  wire logic        debug_int_ack_in,
  input  wire logic        ext_unconditional_in,
  input  wire logic        jtag_unconditional_in,
  input  wire logic        jtag_resume_in,
  input  wire reg_req_t    req_in,
  output logic [31:0]      rdata_out,
  output logic             debug_event_out,
  output logic             debug_int_out,
  output logic             stop_out,
  output logic             trap_suppress_out
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] debug_control_0;
  logic [31:0] debug_event_status;
  logic [31:0] debug_return_address;
  logic [31:0] cmp_addr [4];
  logic        pending;

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_level;
  logic [2:0] pin_level_d;
  logic [2:0] pin_rise;

  logic [1:0] hit_a;
  logic [1:0] hit_b;
  logic       range_ev_a;
  logic       range_ev_b;
  logic [3:0] iac_hit;
  logic [3:0] iac_status;
  logic       iac_ev;
  logic       exc_ev;
  logic       trap_ev;
  logic       ude_ev;
  logic       any_ev;
  logic       quiet;
  logic       ctrl_wr;
  logic       status_wr;
  logic [31:0] next_status;
  logic [31:0] next_control;

  logic ext_mode;
  logic int_mode;
  logic wait_mode;
  logic de;

  assign ext_mode  = debug_control_0[CTL_EXT_MODE];
  assign int_mode  = debug_control_0[CTL_INT_MODE];
  assign wait_mode = debug_control_0[CTL_WAIT_MODE];
  assign de        = debug_int_enable_in;
  assign ctrl_wr   = req_in.wr && (req_in.addr == OFS_CONTROL);
  assign status_wr = req_in.wr && (req_in.addr == OFS_STATUS);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1       <= 3'h0;
      sync2       <= 3'h0;
      sync3       <= 3'h0;
      pin_level   <= 3'h0;
      pin_level_d <= 3'h0;
    end else begin
      sync1       <= {jtag_resume_in, jtag_unconditional_in,
                      ext_unconditional_in};
      sync2       <= sync1;
      sync3       <= sync2;
      pin_level   <= (sync2 & sync3) | (pin_level & (sync2 ^ sync3));
      pin_level_d <= pin_level;
    end
  end

  assign pin_rise = pin_level & ~pin_level_d;

  // ****************************************
  // Event detection
  // ****************************************
  iaddr_pair_match pair_a (
    .addr_in       (step_in.addr),
    .low_in        (cmp_addr[0]),
    .high_in       (cmp_addr[1]),
    .enable_in     (debug_control_0[CTL_IA_EN+1:CTL_IA_EN]),
    .range_in      (debug_control_0[CTL_RANGE_A]),
    .exclusive_in  (debug_control_0[CTL_EXCL_A]),
    .hit_out       (hit_a),
    .range_hit_out (range_ev_a)
  );

  iaddr_pair_match pair_b (
    .addr_in       (step_in.addr),
    .low_in        (cmp_addr[2]),
    .high_in       (cmp_addr[3]),
    .enable_in     (debug_control_0[CTL_IA_EN+3:CTL_IA_EN+2]),
    .range_in      (debug_control_0[CTL_RANGE_B]),
    .exclusive_in  (debug_control_0[CTL_EXCL_B]),
    .hit_out       (hit_b),
    .range_hit_out (range_ev_b)
  );

  // Only resolved steps are checked
  assign iac_hit = step_in.valid ? {hit_b, hit_a} : 4'h0;
  assign iac_ev  = |iac_hit;

  // Quiet: internal mode, debug interrupts disabled, external mode off
  assign quiet = int_mode && !de && !ext_mode;

  // Toggled pairs skip status while quiet
  always_comb begin
    iac_status = iac_hit;
    if (quiet && debug_control_0[CTL_TOGGLE_A] &&
        debug_control_0[CTL_RANGE_A]) begin
      iac_status[1:0] = 2'h0;
    end
    if (quiet && debug_control_0[CTL_TOGGLE_B] &&
        debug_control_0[CTL_RANGE_B]) begin
      iac_status[3:2] = 2'h0;
    end
  end

  assign exc_ev = step_in.exc_taken && debug_control_0[CTL_EXC_EN] &&
                  (!step_in.exc_critical || ext_mode);
  assign trap_ev = step_in.valid && step_in.trap_hit &&
                   debug_control_0[CTL_TRAP_EN];
  assign ude_ev  = pin_rise[0] || pin_rise[1];
  assign any_ev  = exc_ev || trap_ev || ude_ev || iac_ev;

  // ****************************************
  // Status register
  // ****************************************
  always_comb begin
    next_status = debug_event_status;
    if (status_wr) begin
      next_status = next_status & ~req_in.wdata;
    end
    // Set wins over a clear in the same cycle
    next_status[ST_EXC]  = next_status[ST_EXC] | exc_ev;
    next_status[ST_TRAP] = next_status[ST_TRAP] | trap_ev;
    next_status[ST_UNC]  = next_status[ST_UNC] | ude_ev;
    next_status[ST_IMP]  = next_status[ST_IMP] |
                           (trap_ev && int_mode && !de);
    next_status[ST_IA+3:ST_IA] = next_status[ST_IA+3:ST_IA] |
                                 iac_status;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_event_status <= STATUS_RESET;
    end else begin
      debug_event_status <= next_status & STATUS_MASK;
    end
  end

  // ****************************************
  // Control register with range toggling
  // ****************************************
  always_comb begin
    next_control = debug_control_0;
    if (ctrl_wr) begin
      next_control = req_in.wdata & CONTROL_MASK;
    end
    if (step_in.valid && range_ev_a && debug_control_0[CTL_TOGGLE_A]) begin
      next_control[CTL_EXCL_A] = ~debug_control_0[CTL_EXCL_A];
    end
    if (step_in.valid && range_ev_b && debug_control_0[CTL_TOGGLE_B]) begin
      next_control[CTL_EXCL_B] = ~debug_control_0[CTL_EXCL_B];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_control_0 <= CONTROL_RESET;
    end else begin
      debug_control_0 <= next_control;
    end
  end

  // ****************************************
  // Compare registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        cmp_addr[i] <= CMP_RESET;
      end
    end else if (req_in.wr) begin
      unique case (req_in.addr)
        OFS_CMP_1: cmp_addr[0] <= req_in.wdata;
        OFS_CMP_2: cmp_addr[1] <= req_in.wdata;
        OFS_CMP_3: cmp_addr[2] <= req_in.wdata;
        OFS_CMP_4: cmp_addr[3] <= req_in.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Return address
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_return_address <= RETURN_RESET;
    end else if (de) begin
      if (ude_ev) begin
        debug_return_address <= step_in.next_addr;
      end else if (exc_ev) begin
        debug_return_address <= step_in.exc_vector;
      end else if (trap_ev || iac_ev) begin
        debug_return_address <= step_in.addr;
      end
    end
  end

  // ****************************************
  // Event outputs, halt and pending interrupt
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_event_out   <= 1'b0;
      trap_suppress_out <= 1'b0;
    end else begin
      debug_event_out   <= any_ev;
      trap_suppress_out <= trap_ev &&
                           ((int_mode && de) || ext_mode || wait_mode);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stop_out <= 1'b0;
    end else if (any_ev && (ext_mode || wait_mode)) begin
      stop_out <= 1'b1;
    end else if (pin_rise[2]) begin
      stop_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pending <= 1'b0;
    end else if (any_ev && int_mode) begin
      pending <= 1'b1;
    end else if (debug_int_ack_in) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_int_out <= 1'b0;
    end else begin
      debug_int_out <= (pending || (any_ev && int_mode)) && de &&
                       !debug_int_ack_in;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (req_in.rd) begin
      unique case (req_in.addr)
        OFS_CONTROL: rdata_out <= debug_control_0;
        OFS_STATUS:  rdata_out <= debug_event_status;
        OFS_RETURN:  rdata_out <= debug_return_address;
        OFS_CMP_1:   rdata_out <= cmp_addr[0];
        OFS_CMP_2:   rdata_out <= cmp_addr[1];
        OFS_CMP_3:   rdata_out <= cmp_addr[2];
        OFS_CMP_4:   rdata_out <= cmp_addr[3];
        default:     rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  exc_status_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    step_in.exc_taken && !step_in.exc_critical &&
    debug_control_0[CTL_EXC_EN] |=> debug_event_status[ST_EXC])
    else $error("exception event did not set status");

  critical_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    step_in.exc_taken && step_in.exc_critical && !ext_mode |-> !exc_ev)
    else $error("critical exception event without external mode");

  vector_return_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    exc_ev && !ude_ev && de |=>
    debug_return_address == $past(step_in.exc_vector))
    else $error("return address is not the vector");

  trap_suppress_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    trap_ev && ext_mode |=> trap_suppress_out && debug_event_out)
    else $error("trap exception not suppressed");

  imprecise_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    trap_ev && int_mode && !de && !ext_mode && !wait_mode |=>
    debug_event_status[ST_IMP] && !trap_suppress_out)
    else $error("imprecise flag not set");

  unconditional_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(pin_level[0]) |=> debug_event_status[ST_UNC])
    else $error("unconditional event lost");

  status_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !status_wr |=>
    (debug_event_status & $past(debug_event_status)) ==
    $past(debug_event_status))
    else $error("status bit cleared by hardware");

  range_incl_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    step_in.valid && debug_control_0[CTL_RANGE_A] &&
    !debug_control_0[CTL_EXCL_A] && debug_control_0[CTL_IA_EN] &&
    !debug_control_0[CTL_TOGGLE_A] &&
    step_in.addr >= cmp_addr[0] && step_in.addr < cmp_addr[1] |=>
    debug_event_status[ST_IA])
    else $error("inclusive range match missed");

  toggle_flip_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    step_in.valid && range_ev_a && debug_control_0[CTL_TOGGLE_A] &&
    !ctrl_wr |=> debug_control_0[CTL_EXCL_A] != $past(debug_control_0[CTL_EXCL_A]))
    else $error("exclusive bit did not toggle");

  halt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    any_ev && ext_mode |=> stop_out [*2])
    else $error("external mode did not halt");

endmodule

/* File: src/iaddr_pair_match.sv */
/*
 * Address compare for one pair of compare registers: exact match on
 * each register, or an inclusive or exclusive range over the pair.
 * Assumes purely combinational use inside the detector.
 */
`timescale 1ns/1ps
module iaddr_pair_match (
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] low_in,
  input  wire logic [31:0] high_in,
  input  wire logic [1:0]  enable_in,
  input  wire logic        range_in,
  input  wire logic        exclusive_in,
  output logic      [1:0]  hit_out,
  output logic             range_hit_out
);

  logic in_window;
  logic range_match;
  logic [1:0] exact;

  // Unsigned window from low up to high minus one
  assign in_window   = (addr_in >= low_in) && (addr_in < high_in);
  assign range_match = exclusive_in ? !in_window : in_window;
  assign exact = {addr_in == high_in, addr_in == low_in} & enable_in;

  always_comb begin
    if (range_in) begin
      hit_out = range_match ? enable_in : 2'h0;
    end else begin
      hit_out = exact;
    end
  end

  assign range_hit_out = range_in && range_match && (|enable_in);

endmodule
